// file: rsw_status_word.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "rsw_regs.svh"

// Functional notes
// - Row A low nibble reports timer outputs nine to twelve, one bit each.
// - Row B holds timer inputs thirteen to sixteen, then their outputs.
// - Phase row: six phase-pair zone flags, transient block, onto-fault trip.
// - Ground row: six ground zone flags, battery over, battery under.
// - Per-phase wear flags at full wear; summary flag is their OR.
// - Fault-ident enabled flag stays low while alternate selection is on.
// - Three fault-select outputs flagged per row and fed to distance logic.
// - Six group flags, the group currently in use asserted.
// - Open command execution pulses the open flag one quarter cycle.
// - Close command execution pulses the close flag one quarter cycle.
// - Close row starts with close output, then quarter-cycle close failure.
// - Target reset pulses one interval on button press or serial command.

module rsw_status_word #(
    parameter int unsigned QTR_TICKS = `RSW_QTR_TICKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rsw_pkg::rsw_raw_s raw,
    input wire rsw_pkg::rsw_evt_s cmd_evt,
    input wire logic [2:0] active_group,
    input wire logic reset_button,
    output logic [2:0] fault_select,
    output logic irq
);
    rsw_pkg::rsw_rows_s rows;
    rsw_pkg::rsw_rows_s next_rows;
    rsw_pkg::rsw_apb_e state;
    rsw_pkg::rsw_apb_e next_state;
    logic tick;
    logic [1:0] btn_sync;
    logic btn_q;
    logic btn_press;
    logic [3:0] pend;
    logic [3:0] next_pend;
    logic [3:0] evt_in;
    logic [5:0] grp_flags;
    logic [7:0] watch_cur;
    logic [7:0] watch_nxt;
    logic [7:0] ev_set;
    logic [7:0] stat;
    logic [7:0] next_stat;
    logic [7:0] stat_clr;
    logic [7:0] mask;
    logic [7:0] next_mask;
    logic alt_fts_en;
    logic next_alt_fts_en;
    logic [31:0] rd_data;
    logic hit;
    logic done;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // ****************************************
    // Processing interval
    // ****************************************
    rsw_tick_gen #(
        .TICKS(QTR_TICKS)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // ****************************************
    // Pushbutton synchroniser and event capture
    // ****************************************
    // Strobes are held until the next tick so that none is missed
    always_comb begin
        btn_press = btn_sync[1] & ~btn_q;
        evt_in = {cmd_evt.open_cmd, cmd_evt.close_cmd, cmd_evt.close_fail,
                  cmd_evt.target_reset | btn_press};
        // Arrival on the tick cycle wins over the clear
        next_pend = evt_in | (pend & {4{~tick}});
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_sync <= 2'b00;
            btn_q <= 1'b0;
            pend <= 4'h0;
        end else begin
            btn_sync <= {btn_sync[0], reset_button};
            btn_q <= btn_sync[1];
            pend <= next_pend;
        end
    end

    // ****************************************
    // Status rows
    // ****************************************
    always_comb begin
        grp_flags = 6'h00;
        if (active_group >= 3'd1 && active_group <= 3'd6) begin
            grp_flags = 6'b100000 >> (active_group - 3'd1);
        end
        next_rows = rows;
        if (tick) begin
            next_rows.timer_outputs_row_a = {4'h0, raw.timer_out_9_12};
            next_rows.timer_inputs_outputs_row_b =
                {raw.timer_in_13_16, raw.timer_out_13_16};
            next_rows.phase_distance_flags = {raw.phase_zone,
                raw.transient_block_active, raw.onto_fault_trip};
            next_rows.ground_distance_battery_flags = {raw.gnd_zone,
                raw.battery_over_flag, raw.battery_under_flag};
            next_rows.wear_fault_select_flags = {|raw.wear_phase,
                raw.wear_phase, raw.fault_ident_active & ~alt_fts_en,
                raw.fault_select};
            next_rows.group_command_flags = {grp_flags, pend[3], pend[2]};
            next_rows.close_logic_flags = {raw.close_logic_out, pend[1],
                pend[0], 5'h00};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rows <= {7{`RSW_ROW_RST}};
        end else begin
            rows <= next_rows;
        end
    end

    // ****************************************
    // Event status and interrupt
    // ****************************************
    always_comb begin
        watch_cur = {rows.group_command_flags[`RSW_OPEN_CMD_BIT],
            rows.group_command_flags[`RSW_CLOSE_CMD_BIT],
            rows.close_logic_flags[`RSW_CLOSE_FAIL_BIT],
            rows.close_logic_flags[`RSW_TRGT_RESET_BIT],
            rows.wear_fault_select_flags[`RSW_WEAR_ANY_BIT],
            rows.ground_distance_battery_flags[1:0],
            rows.phase_distance_flags[0]};
        watch_nxt = {next_rows.group_command_flags[`RSW_OPEN_CMD_BIT],
            next_rows.group_command_flags[`RSW_CLOSE_CMD_BIT],
            next_rows.close_logic_flags[`RSW_CLOSE_FAIL_BIT],
            next_rows.close_logic_flags[`RSW_TRGT_RESET_BIT],
            next_rows.wear_fault_select_flags[`RSW_WEAR_ANY_BIT],
            next_rows.ground_distance_battery_flags[1:0],
            next_rows.phase_distance_flags[0]};
        // Pulse flags may repeat on back-to-back ticks without a rise
        ev_set = (watch_nxt & ~watch_cur) |
            {{4{tick}} & pend, 4'h0};
        // Only bits the read returned are cleared, so late sets survive
        stat_clr = (done && !pwrite && paddr == `RSW_EVENT_STATUS_OFF) ?
            prdata[7:0] : 8'h00;
    end

    for (genvar i = 0; i < 8; i++) begin : g_stat
        assign next_stat[i] = ev_set[i] | (stat[i] & ~stat_clr[i]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat <= `RSW_STATUS_RST;
            irq <= 1'b0;
        end else begin
            stat <= next_stat;
            irq <= |(next_stat & next_mask);
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    always_comb begin
        rd_data = 32'h0000_0000;
        hit = 1'b1;
        unique case (paddr)
            `RSW_TIMER_OUTPUTS_ROW_A_OFF:
                rd_data[7:0] = rows.timer_outputs_row_a;
            `RSW_TIMER_INPUTS_OUTPUTS_ROW_B_OFF:
                rd_data[7:0] = rows.timer_inputs_outputs_row_b;
            `RSW_PHASE_DISTANCE_FLAGS_OFF:
                rd_data[7:0] = rows.phase_distance_flags;
            `RSW_GROUND_DISTANCE_BATTERY_FLAGS_OFF:
                rd_data[7:0] = rows.ground_distance_battery_flags;
            `RSW_WEAR_FAULT_SELECT_FLAGS_OFF:
                rd_data[7:0] = rows.wear_fault_select_flags;
            `RSW_GROUP_COMMAND_FLAGS_OFF:
                rd_data[7:0] = rows.group_command_flags;
            `RSW_CLOSE_LOGIC_FLAGS_OFF:
                rd_data[7:0] = rows.close_logic_flags;
            `RSW_EVENT_STATUS_OFF: rd_data[7:0] = stat;
            `RSW_EVENT_MASK_OFF: rd_data[7:0] = mask;
            `RSW_CONTROL_OFF: rd_data[`RSW_CTRL_ALT_FTS_BIT] = alt_fts_en;
            default: hit = 1'b0;
        endcase
        done = (state == rsw_pkg::RSW_RESP) && psel && penable;
    end

    always_comb begin
        next_state = state;
        next_pready = pready;
        next_prdata = prdata;
        next_pslverr = pslverr;
        next_mask = mask;
        next_alt_fts_en = alt_fts_en;
        unique case (state)
            rsw_pkg::RSW_IDLE: begin
                if (psel && !penable) begin
                    next_state = rsw_pkg::RSW_RESP;
                    next_pready = 1'b1;
                    next_prdata = pwrite ? 32'h0000_0000 : rd_data;
                    next_pslverr = ~hit;
                end
            end
            rsw_pkg::RSW_RESP: begin
                if (done) begin
                    next_state = rsw_pkg::RSW_IDLE;
                    next_pready = 1'b0;
                    next_pslverr = 1'b0;
                    if (pwrite && paddr == `RSW_EVENT_MASK_OFF) begin
                        next_mask = pwdata[7:0];
                    end
                    if (pwrite && paddr == `RSW_CONTROL_OFF) begin
                        next_alt_fts_en = pwdata[`RSW_CTRL_ALT_FTS_BIT];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= rsw_pkg::RSW_IDLE;
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            mask <= `RSW_MASK_RST;
            alt_fts_en <= `RSW_CONTROL_RST;
            fault_select <= 3'h0;
        end else begin
            state <= next_state;
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            mask <= next_mask;
            alt_fts_en <= next_alt_fts_en;
            fault_select <= next_rows.wear_fault_select_flags[2:0];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_open_fire;
        tick && pend[3];
    endsequence
    sequence s_btn_press;
        btn_sync[1] && !btn_q;
    endsequence

    property p_row_a;
        tick |=> rows.timer_outputs_row_a == {4'h0, $past(raw.timer_out_9_12)};
    endproperty
    a_row_a: assert property (p_row_a) else $error("row A wrong");
    property p_row_b;
        tick |=> rows.timer_inputs_outputs_row_b ==
            {$past(raw.timer_in_13_16), $past(raw.timer_out_13_16)};
    endproperty
    a_row_b: assert property (p_row_b) else $error("row B wrong");
    property p_phase;
        tick |=> rows.phase_distance_flags[7:2] == $past(raw.phase_zone) &&
            rows.phase_distance_flags[0] == $past(raw.onto_fault_trip);
    endproperty
    a_phase: assert property (p_phase) else $error("phase row");
    property p_ground;
        tick |=> rows.ground_distance_battery_flags[1] ==
            $past(raw.battery_over_flag);
    endproperty
    a_ground: assert property (p_ground) else $error("battery flag");
    property p_wear;
        rows.wear_fault_select_flags[`RSW_WEAR_ANY_BIT] ==
            |rows.wear_fault_select_flags[6:4];
    endproperty
    a_wear: assert property (p_wear) else $error("wear summary");
    property p_fault_ident_enabled;
        tick && alt_fts_en |=> !rows.wear_fault_select_flags[`RSW_FAULT_IDENT_ENABLED_BIT];
    endproperty
    a_fault_ident_enabled: assert property (p_fault_ident_enabled) else $error("fault_ident_enabled set");
    property p_fsel;
        tick |=> ##1 fault_select == $past(raw.fault_select, 2);
    endproperty
    a_fsel: assert property (p_fsel) else $error("fault select");
    property p_group;
        tick && active_group == 3'd2 |=>
            rows.group_command_flags[7:2] == 6'b010000;
    endproperty
    a_group: assert property (p_group) else $error("group flags");
    property p_open;
        s_open_fire |=> rows.group_command_flags[`RSW_OPEN_CMD_BIT];
    endproperty
    a_open: assert property (p_open) else $error("open pulse");
    property p_close;
        $rose(rows.group_command_flags[`RSW_CLOSE_CMD_BIT]) |->
            $past(tick) && $past(pend[2]);
    endproperty
    a_close: assert property (p_close) else $error("close pulse");
    property p_cfail;
        tick && !pend[1] |=> !rows.close_logic_flags[`RSW_CLOSE_FAIL_BIT];
    endproperty
    a_cfail: assert property (p_cfail) else $error("cfail long");
    property p_trgt;
        s_btn_press |=> pend[0];
    endproperty
    a_trgt: assert property (p_trgt) else $error("reset lost");
    property p_hold;
        !$past(tick) |-> $stable(rows);
    endproperty
    a_hold: assert property (p_hold) else $error("off-tick change");
endmodule

// file: rsw_regs.svh
`ifndef RSW_REGS_SVH
`define RSW_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define RSW_TIMER_OUTPUTS_ROW_A_OFF 8'h00
`define RSW_TIMER_INPUTS_OUTPUTS_ROW_B_OFF 8'h04
`define RSW_PHASE_DISTANCE_FLAGS_OFF 8'h08
`define RSW_GROUND_DISTANCE_BATTERY_FLAGS_OFF 8'h0C
`define RSW_WEAR_FAULT_SELECT_FLAGS_OFF 8'h10
`define RSW_GROUP_COMMAND_FLAGS_OFF 8'h14
`define RSW_CLOSE_LOGIC_FLAGS_OFF 8'h18
`define RSW_EVENT_STATUS_OFF 8'h1C
`define RSW_EVENT_MASK_OFF 8'h20
`define RSW_CONTROL_OFF 8'h24

// ****************************************
// Reset values
// ****************************************
`define RSW_ROW_RST 8'h00
`define RSW_STATUS_RST 8'h00
`define RSW_MASK_RST 8'h00
`define RSW_CONTROL_RST 1'b0

// ****************************************
// Field positions
// ****************************************
`define RSW_CTRL_ALT_FTS_BIT 0
`define RSW_WEAR_ANY_BIT 7
`define RSW_FAULT_IDENT_ENABLED_BIT 3
`define RSW_OPEN_CMD_BIT 1
`define RSW_CLOSE_CMD_BIT 0
`define RSW_CLOSE_LOGIC_BIT 7
`define RSW_CLOSE_FAIL_BIT 6
`define RSW_TRGT_RESET_BIT 5
`define RSW_EV_OPEN_BIT 7
`define RSW_EV_CLOSE_BIT 6
`define RSW_EV_CFAIL_BIT 5
`define RSW_EV_TRGT_BIT 4
`define RSW_EV_WEAR_BIT 3
`define RSW_EV_BAT_OVER_BIT 2
`define RSW_EV_BAT_UNDER_BIT 1
`define RSW_EV_SOTF_BIT 0

// ****************************************
// Timing
// ****************************************
`define RSW_CLK_NS 8
`define RSW_LINE_HZ 60
`define RSW_QTR_CYCLE_NS (1000000000 / (4 * `RSW_LINE_HZ))
`define RSW_QTR_TICKS (`RSW_QTR_CYCLE_NS / `RSW_CLK_NS)

`endif

// file: rsw_pkg.sv
package rsw_pkg;

    // Raw flags from the protection logic, first listed bit is the MSB
    typedef struct packed {
        logic [3:0] timer_out_9_12;
        logic [3:0] timer_in_13_16;
        logic [3:0] timer_out_13_16;
        logic [5:0] phase_zone;
        logic transient_block_active;
        logic onto_fault_trip;
        logic [5:0] gnd_zone;
        logic battery_over_flag;
        logic battery_under_flag;
        logic [2:0] wear_phase;
        logic fault_ident_active;
        logic [2:0] fault_select;
        logic close_logic_out;
    } rsw_raw_s;

    // One-cycle execution strobes
    typedef struct packed {
        logic open_cmd;
        logic close_cmd;
        logic close_fail;
        logic target_reset;
    } rsw_evt_s;

    typedef struct packed {
        logic [7:0] timer_outputs_row_a;
        logic [7:0] timer_inputs_outputs_row_b;
        logic [7:0] phase_distance_flags;
        logic [7:0] ground_distance_battery_flags;
        logic [7:0] wear_fault_select_flags;
        logic [7:0] group_command_flags;
        logic [7:0] close_logic_flags;
    } rsw_rows_s;

    typedef enum logic [1:0] {
        RSW_IDLE = 2'b00,
        RSW_RESP = 2'b01
    } rsw_apb_e;

endpackage

// file: rsw_tick_gen.sv
`timescale 1ns/1ps

module rsw_tick_gen #(
    parameter int unsigned TICKS = 520833
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    localparam int CW = $clog2(TICKS + 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic next_tick;

    always_comb begin
        next_tick = (cnt == CW'(TICKS - 1));
        next_cnt = next_tick ? '0 : cnt + CW'(1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// file: relay_status_word_rows_tb_top.sv
`timescale 1ns/1ps
`include "rsw_regs.svh"

module relay_status_word_rows_tb_top;
    // Short quarter cycle keeps the run brief
    localparam int Q = 8;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rsw_pkg::rsw_raw_s raw;
    rsw_pkg::rsw_raw_s r;
    rsw_pkg::rsw_evt_s cmd_evt;
    logic [2:0] active_group;
    logic reset_button;
    logic [2:0] fault_select;
    logic irq;
    logic [31:0] d;
    logic e;
    logic alt;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'h55e35f5e;
    int n;

    rsw_status_word #(.QTR_TICKS(Q)) u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .raw(raw),
        .cmd_evt(cmd_evt),
        .active_group(active_group),
        .reset_button(reset_button),
        .fault_select(fault_select),
        .irq(irq)
    );

    // ****************************************
    // Clock, timeout and reporting
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Whole run needs about a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("unexpected at %0t: run hung", $time);
            stop_test();
        end
    end

    task stop_test;
        $display("compares %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp,
             input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state count assumed; only the run timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ****************************************
    // Expected values
    // ****************************************
    function automatic logic [7:0] grp(input logic [2:0] g);
        grp = (g >= 3'h1 && g <= 3'h6) ? (8'h80 >> (g - 3'h1)) : 8'h00;
    endfunction

    function automatic logic [31:0] exp_row(input int k,
        input rsw_pkg::rsw_raw_s x, input logic [2:0] g, input logic a);
        case (k)
            0: exp_row = {28'h0, x.timer_out_9_12};
            1: exp_row = {24'h0, x.timer_in_13_16, x.timer_out_13_16};
            2: exp_row = {24'h0, x.phase_zone, x.transient_block_active,
                          x.onto_fault_trip};
            3: exp_row = {24'h0, x.gnd_zone, x.battery_over_flag,
                          x.battery_under_flag};
            4: exp_row = {24'h0, |x.wear_phase, x.wear_phase,
                          x.fault_ident_active & ~a, x.fault_select};
            5: exp_row = {24'h0, grp(g)};
            default: exp_row = {24'h0, x.close_logic_out, 7'h0};
        endcase
    endfunction

    // Pulse rows with group three active and all raw flags low
    function automatic logic [31:0] exp_pulse(input int k, input logic on);
        if (k < 2)
            exp_pulse = {24'h0, grp(3'h3) | (on ? (8'h02 >> k) : 8'h00)};
        else
            exp_pulse = {24'h0, on ? (k == 2 ? 8'h40 : 8'h20) : 8'h00};
    endfunction

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        raw = '0;
        cmd_evt = '0;
        active_group = 3'h0;
        reset_button = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 10; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            chk(d, 32'h0, "reset value");
        end
        apb(1'b1, `RSW_GROUP_COMMAND_FLAGS_OFF, 32'hFF);
        chk({31'h0, e}, 32'h0, "row write response");
        apb(1'b0, `RSW_GROUP_COMMAND_FLAGS_OFF, 32'h0);
        chk(d, 32'h0, "row write ignored");
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped read error");
        chk(d, 32'h0, "unmapped read data");
        apb(1'b1, 8'h40, 32'hFF);
        chk({31'h0, e}, 32'h1, "unmapped write error");
        $display("test reset and access done");

        // Random flags, every group value, alternate selection both ways
        for (int i = 0; i < 16; i++) begin
            r = 36'({$random(seed), $random(seed)});
            r.fault_ident_active = i[0];
            alt = i[1];
            apb(1'b1, `RSW_CONTROL_OFF, {31'h0, alt});
            raw <= r;
            active_group <= 3'(i);
            repeat (2 * Q + 2) @(posedge pclk);
            for (int k = 0; k < 7; k++) begin
                apb(1'b0, 8'(4 * k), 32'h0);
                chk(d, exp_row(k, r, 3'(i), alt), "row");
            end
            chk({29'h0, fault_select}, {29'h0, r.fault_select}, "fsel");
        end
        $display("test flag rows done");

        raw <= '0;
        active_group <= 3'h3;
        repeat (2 * Q + 2) @(posedge pclk);
        apb(1'b0, `RSW_EVENT_STATUS_OFF, 32'h0);
        apb(1'b1, `RSW_EVENT_MASK_OFF, 32'hFF);
        apb(1'b0, `RSW_EVENT_MASK_OFF, 32'h0);
        chk(d, 32'hFF, "mask readback");
        // Open, close, close failure, serial reset, then the button
        for (int k = 0; k < 5; k++) begin
            @(posedge pclk);
            if (k == 4)
                reset_button <= 1'b1;
            else
                cmd_evt <= 4'(4'h8 >> k);
            @(posedge pclk);
            cmd_evt <= '0;
            reset_button <= 1'b0;
            n = 0;
            while (irq !== 1'b1 && n < 4 * Q) begin
                @(posedge pclk);
                n++;
            end
            chk({31'h0, irq}, 32'h1, "irq raised");
            apb(1'b0, k < 2 ? `RSW_GROUP_COMMAND_FLAGS_OFF :
                `RSW_CLOSE_LOGIC_FLAGS_OFF, 32'h0);
            chk(d, exp_pulse(k, 1'b1), "pulse high");
            apb(1'b0, `RSW_EVENT_STATUS_OFF, 32'h0);
            chk(d, 32'h80 >> (k == 4 ? 3 : k), "status");
            apb(1'b0, `RSW_EVENT_STATUS_OFF, 32'h0);
            chk(d, 32'h0, "status cleared by read");
            chk({31'h0, irq}, 32'h0, "irq cleared");
            repeat (2 * Q) @(posedge pclk);
            apb(1'b0, k < 2 ? `RSW_GROUP_COMMAND_FLAGS_OFF :
                `RSW_CLOSE_LOGIC_FLAGS_OFF, 32'h0);
            chk(d, exp_pulse(k, 1'b0), "pulse ended");
        end
        $display("test pulses done");

        // Masked event still sets status but keeps irq low
        apb(1'b1, `RSW_EVENT_MASK_OFF, 32'h0);
        @(posedge pclk);
        cmd_evt <= 4'h8;
        @(posedge pclk);
        cmd_evt <= '0;
        repeat (2 * Q + 2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b0, `RSW_EVENT_STATUS_OFF, 32'h0);
        chk(d, 32'h80, "masked status");
        $display("test mask done");
        stop_test();
    end
endmodule
